// File: rtl/fpp_params.svh
// constants for the fast passive parallel configuration host
`ifndef FPP_PARAMS_SVH
`define FPP_PARAMS_SVH
`define CLK_MHZ 100
`define POR_LONG_MS 100
`define POR_SHORT_MS 2
`define REQ_LOW_US 2
`define ST2CK_US 2
`define CF2CK_US 100
`define TAIL_CLKS 64
`define CLK_HALF 4
`define REG_CTRL 8'h00
`define REG_DATA 8'h04
`define REG_STAT 8'h08
`define CTRL_START 0
`define CTRL_UCLK 1
`define CTRL_REQ 2
`define DATA_LAST 8
`define BYTE_IDLE 8'hff
`endif

// File: rtl/fpp_pkg.sv
// types shared by the configuration host
package fpp_pkg;
  typedef enum logic [3:0] {
    S_POR = 4'h0,
    S_IDLE = 4'h1,
    S_REQ = 4'h2,
    S_REQWAIT = 4'h3,
    S_WAITST = 4'h4,
    S_SETTLE = 4'h5,
    S_LOAD = 4'h6,
    S_TAIL = 4'h7,
    S_DONE = 4'h8,
    S_ERROR = 4'h9
  } host_state_t;
endpackage

// File: rtl/sync2.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
`default_nettype wire

// File: rtl/cfg_clk_gen.sv
// one configuration clock pulse per request, low then high
`timescale 1ns/10ps
`default_nettype none
module cfg_clk_gen #(
  parameter int HALF = 4
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_go,
  output logic o_clk,
  output logic o_busy
);
  logic [7:0] cnt;

  // low half gives data setup, high half ends with the fall so data holds a half period
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 8'h00;
      o_clk <= 1'b0;
      o_busy <= 1'b0;
    end else if (!o_busy) begin
      cnt <= 8'h00;
      o_clk <= 1'b0;
      o_busy <= i_go;
    end else begin
      cnt <= cnt + 8'h01;
      if (cnt == 8'(HALF - 1)) begin
        o_clk <= 1'b1;
      end
      if (cnt == 8'(2 * HALF - 1)) begin
        o_clk <= 1'b0;
        o_busy <= 1'b0;
      end
    end
  end

  property p_one_edge_per_go;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_go && !o_busy) |=> ##HALF $rose(o_clk) ##HALF $fell(o_clk);
  endproperty
  a_one_edge_per_go: assert property (p_one_edge_per_go) else $error("clock pulse shape wrong");
endmodule
`default_nettype wire

// File: rtl/fpp_config_host.sv
// configuration source: streams bytes from apb writes to the target over the parallel link
// Notes on behaviour
// - one byte per configuration clock cycle
// - bytes sent uncompressed, decompression done before software writes them
// - own power-on delay holds enable low
// - target should finish power-on first
// - release open-drain line after power-on
// - holding request or status low postpones start
// - clock data once status line goes high
// - go quiet when completion line rises
// - user clock at most 100 MHz
// - at end drive clock low, bytes high
// - request line driven by init request output
// - 64 clocks for completion, else flag failure
// - reconfigure with request low at least 2 us
`include "fpp_params.svh"
`timescale 1ns/10ps
`default_nettype none
module fpp_config_host
  import fpp_pkg::*;
#(
  parameter int unsigned POR_LONG_CYC = `POR_LONG_MS * 1000 * `CLK_MHZ,
  parameter int unsigned POR_SHORT_CYC = `POR_SHORT_MS * 1000 * `CLK_MHZ,
  parameter int unsigned CF2CK_CYC = `CF2CK_US * `CLK_MHZ
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_por_select,
  input wire logic i_status_line,
  output logic o_status_out,
  output logic o_status_oe,
  input wire logic i_complete_line,
  input wire logic i_request_line,
  output logic o_request_out,
  output logic o_request_oe,
  output logic o_config_clock,
  output logic [7:0] o_config_byte,
  output logic o_user_clock
);
  localparam logic [23:0] REQ_CYC = 24'(`REQ_LOW_US * `CLK_MHZ);
  localparam logic [23:0] ST2CK_CYC = 24'(`ST2CK_US * `CLK_MHZ);
  localparam logic [23:0] POR_L = 24'(POR_LONG_CYC);
  localparam logic [23:0] POR_S = 24'(POR_SHORT_CYC);
  localparam logic [23:0] CF2CK = 24'(CF2CK_CYC);
  localparam logic [6:0] TAIL_N = 7'(`TAIL_CLKS);

  logic rst_meta;
  logic rst_n;
  logic status_s;
  logic complete_s;
  logic por_sel_s;
  logic request_s;
  host_state_t state;
  host_state_t next_state;
  logic [23:0] cnt;
  logic [23:0] por_lim;
  logic [6:0] tail_n;
  logic busy;
  logic last_q;
  logic uclk_en;
  logic use_req;
  logic err;
  logic access;
  logic setup;
  logic hit_ctrl;
  logic hit_data;
  logic hit_stat;
  logic data_wr;
  logic data_go;
  logic tail_go;
  logic start;
  logic quiet;

  // reset released through two flops so every block leaves reset together
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // pin levels from the link and the strap
  sync2 #(
    .W(4)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rstn(rst_n),
    .i_d({i_status_line, i_complete_line, i_por_select, i_request_line}),
    .o_q({status_s, complete_s, por_sel_s, request_s})
  );

  // apb decode; only a data write in the load state that finds the clock busy is stalled
  assign access = i_psel && i_penable;
  assign setup = i_psel && !i_penable;
  assign hit_ctrl = (i_paddr == `REG_CTRL);
  assign hit_data = (i_paddr == `REG_DATA);
  assign hit_stat = (i_paddr == `REG_STAT);
  assign data_wr = access && i_pwrite && hit_data;
  assign o_pready = !(data_wr && state == S_LOAD && busy);
  assign o_pslverr = access && !(hit_ctrl || hit_data || hit_stat);
  assign data_go = data_wr && state == S_LOAD && !busy;
  assign start = access && i_pwrite && hit_ctrl && i_pwdata[`CTRL_START];
  assign quiet = (state == S_IDLE) || (state == S_DONE) || (state == S_ERROR);

  // read data captured in the setup phase, stable through the access
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup && !i_pwrite) begin
      if (hit_ctrl) begin
        o_prdata <= {29'h0, use_req, uclk_en, 1'b0};
      end else if (hit_stat) begin
        o_prdata <= {22'h0, request_s, err, state, status_s, complete_s, busy, last_q};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // control bits written by software
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      uclk_en <= 1'b0;
      use_req <= 1'b0;
    end else if (access && i_pwrite && hit_ctrl) begin
      uclk_en <= i_pwdata[`CTRL_UCLK];
      use_req <= i_pwdata[`CTRL_REQ];
    end
  end

  // own power-on delay picked by the strap; long default lets the target finish first
  assign por_lim = por_sel_s ? POR_S : POR_L;

  // state sequencing
  always_comb begin
    next_state = state;
    case (state)
      S_POR: begin
        if (cnt >= por_lim - 24'h1) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE, S_DONE, S_ERROR: begin
        if (start) begin
          next_state = use_req ? S_REQ : S_WAITST;
        end
      end
      S_REQ: begin
        if (cnt == REQ_CYC - 24'h1) begin
          next_state = S_REQWAIT;
        end
      end
      S_REQWAIT: begin
        if (cnt == CF2CK - 24'h1) begin
          next_state = S_WAITST;
        end
      end
      S_WAITST: begin
        if (status_s) begin
          next_state = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (!status_s) begin
          next_state = S_WAITST;
        end else if (cnt == ST2CK_CYC - 24'h1) begin
          next_state = S_LOAD;
        end
      end
      S_LOAD: begin
        if (complete_s) begin
          next_state = S_DONE;
        end else if (!status_s) begin
          next_state = S_ERROR;
        end else if (last_q && !busy && !data_go) begin
          next_state = S_TAIL;
        end
      end
      S_TAIL: begin
        if (complete_s) begin
          next_state = S_DONE;
        end else if (!status_s || (tail_n == TAIL_N && !busy)) begin
          next_state = S_ERROR;
        end
      end
      default: begin
        next_state = S_POR;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_POR;
    end else begin
      state <= next_state;
    end
  end

  // one shared delay counter, restarted on every state change
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 24'h0;
    end else if (next_state != state) begin
      cnt <= 24'h0;
    end else if (cnt != 24'hff_ffff) begin
      cnt <= cnt + 24'h1;
    end
  end

  // trailing clocks after the last byte while waiting for completion
  assign tail_go = (state == S_TAIL) && !busy && (tail_n != TAIL_N) && !complete_s;
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      tail_n <= 7'h0;
    end else if (state != S_TAIL) begin
      tail_n <= 7'h0;
    end else if (tail_go) begin
      tail_n <= tail_n + 7'h1;
    end
  end

  cfg_clk_gen #(
    .HALF(`CLK_HALF)
  ) u_clk (
    .i_mclk(i_mclk),
    .i_rstn(rst_n),
    .i_go(data_go || tail_go),
    .o_clk(o_config_clock),
    .o_busy(busy)
  );

  // bytes pass through untouched; any compression is undone before software writes them
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_config_byte <= `BYTE_IDLE;
      last_q <= 1'b0;
    end else if (data_go) begin
      o_config_byte <= i_pwdata[7:0];
      last_q <= i_pwdata[`DATA_LAST];
    end else if (state != S_LOAD) begin
      // on completion the rising edge of any pulse in flight has already passed; on an abort to error the byte parks even before it rises
      o_config_byte <= `BYTE_IDLE;
      last_q <= 1'b0;
    end
  end

  // failure flag, kept until the next start
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      err <= 1'b0;
    end else if (next_state == S_ERROR) begin
      err <= 1'b1;
    end else if (start && quiet) begin
      err <= 1'b0;
    end
  end

  // open-drain drives: only ever pull low
  assign o_status_out = 1'b0;
  assign o_request_out = 1'b0;
  assign o_status_oe = (state == S_POR) || (state == S_ERROR);
  assign o_request_oe = (state == S_REQ);

  // user start-up clock at half the system rate keeps it under the limit
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_user_clock <= 1'b0;
    end else if (uclk_en) begin
      o_user_clock <= !o_user_clock;
    end else begin
      o_user_clock <= 1'b0;
    end
  end

  sequence s_tail_out;
    state == S_TAIL && tail_n == TAIL_N && !busy && status_s && !complete_s;
  endsequence
  sequence s_flag_fail;
    state == S_ERROR ##1 o_status_oe;
  endsequence

  property p_por_hold;
    @(posedge i_mclk) disable iff (!rst_n)
    (state == S_POR) |-> o_status_oe && !o_config_clock;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("enable not held low in power-on");

  property p_por_len;
    @(posedge i_mclk) disable iff (!rst_n)
    (state == S_POR && cnt < por_lim - 24'h1) |=> state == S_POR;
  endproperty
  a_por_len: assert property (p_por_len) else $error("power-on delay cut short");

  property p_req_len;
    @(posedge i_mclk) disable iff (!rst_n)
    $fell(o_request_oe) |-> $past(cnt) == REQ_CYC - 24'h1;
  endproperty
  a_req_len: assert property (p_req_len) else $error("request low pulse wrong length");

  property p_load_after_status;
    @(posedge i_mclk) disable iff (!rst_n)
    $rose(state == S_LOAD) |-> $past(status_s) && $past(cnt) == ST2CK_CYC - 24'h1;
  endproperty
  a_load_after_status: assert property (p_load_after_status) else $error("clocking before status high");

  property p_deselect;
    @(posedge i_mclk) disable iff (!rst_n)
    (complete_s && (state == S_LOAD || state == S_TAIL)) |=> state == S_DONE;
  endproperty
  a_deselect: assert property (p_deselect) else $error("not stopped on completion");

  property p_end_levels;
    @(posedge i_mclk) disable iff (!rst_n)
    (state == S_DONE && !busy) |-> !o_config_clock && o_config_byte == 8'hff;
  endproperty
  a_end_levels: assert property (p_end_levels) else $error("link not parked after end");

  property p_tail_fail;
    @(posedge i_mclk) disable iff (!rst_n)
    s_tail_out |=> s_flag_fail;
  endproperty
  a_tail_fail: assert property (p_tail_fail) else $error("missing failure after trailing clocks");

  property p_user_clk_rate;
    @(posedge i_mclk) disable iff (!rst_n)
    (uclk_en && $past(uclk_en)) |-> o_user_clock != $past(o_user_clock);
  endproperty
  a_user_clk_rate: assert property (p_user_clk_rate) else $error("user clock not toggling");
endmodule
`default_nettype wire

// File: test/fpp_target_model.sv
// behavioural target device on the configuration link
`timescale 1ns/10ps
`default_nettype none
module fpp_target_model #(
  parameter int POR_SHORT = 120,
  parameter int POR_LONG = 600,
  parameter int NBYTES = 4,
  parameter int INT_INIT = 100,
  parameter int CD2CU = 32
) (
  input wire logic i_mclk,
  input wire logic i_por_select,
  input wire logic i_fail,
  input wire logic i_request_line,
  input wire logic i_status_line,
  input wire logic i_config_clock,
  input wire logic [7:0] i_config_byte,
  input wire logic i_user_clock,
  input wire logic i_use_uclk,
  input wire logic i_pullup_sel_n,
  output logic o_status_oe,
  output logic o_complete_oe,
  output logic o_user_mode,
  output logic o_pullups_on,
  output logic o_init_done_oe
);
  int por_cnt = 0;
  int n_rx = 0;
  int init_cnt = 0;
  int n_uedge = 0;
  logic uclk_q = 1'b0;
  logic bad = 1'b0;
  logic done = 1'b0;
  logic in_por;
  // short select ends power-on well before the host does
  assign in_por = por_cnt < (i_por_select ? POR_SHORT : POR_LONG);
  always @(posedge i_mclk) if (in_por) por_cnt <= por_cnt + 1;
  // status low in power-on, while request is low, or on a commanded fault
  assign o_status_oe = in_por || !i_request_line || i_fail;
  // completion held low until a clean load
  assign o_complete_oe = !done;
  // reset while request or status low; link ignored once done
  always @(posedge i_config_clock or negedge i_request_line or negedge i_status_line) begin
    if (!i_request_line || !i_status_line) begin
      n_rx = 0;
      bad = 1'b0;
      done = 1'b0;
    end else if (!done) begin
      if (i_config_byte !== 8'h50 + n_rx[7:0]) bad = 1'b1;
      n_rx++;
      if (n_rx == NBYTES && !bad) done = 1'b1;
    end
  end
  // initialization after completion: a fixed wait stands in for the internal oscillator
  always @(posedge i_mclk) begin
    uclk_q <= i_user_clock;
    if (!done) begin
      init_cnt <= 0;
      n_uedge <= 0;
    end else begin
      if (init_cnt < 100000) init_cnt <= init_cnt + 1;
      // user clock edges only count once the enable delay has passed
      if (i_user_clock && !uclk_q && init_cnt >= CD2CU) n_uedge <= n_uedge + 1;
    end
  end
  assign o_user_mode = done && (i_use_uclk ? n_uedge >= 299 : init_cnt >= INT_INIT);
  // weak pull-ups from the end of power-on until user mode, when selected
  assign o_pullups_on = !in_por && !i_pullup_sel_n && !o_user_mode;
  // init-done pulled low from the first byte until user mode
  assign o_init_done_oe = i_request_line && n_rx > 0 && !o_user_mode;
endmodule
`default_nettype wire

// File: test/fpp_config_host_bench.sv
// self-checking bench: configuration host driving a target model
`timescale 1ns/10ps
`default_nettype none
`include "fpp_params.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module fpp_config_host_bench import fpp_pkg::*;;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic fail = 1'b0;
  logic por_sel = 1'b1;
  logic use_uclk = 1'b0;
  logic status_out, request_out, user_mode, pullups_on, init_done_oe;
  logic [31:0] prdata;
  logic [7:0] config_byte;
  logic pready, pslverr, status_oe, request_oe, config_clock, user_clock, tgt_status_oe, tgt_complete_oe;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_clk = 0;
  int n_uclk = 0;
  logic [31:0] rd;
  logic err;
  // open-drain lines: low if any party pulls
  wire logic status_line = !(status_oe || tgt_status_oe);
  wire logic complete_line = !tgt_complete_oe;
  wire logic request_line = !request_oe;
  wire logic init_done_line = !init_done_oe;

  fpp_config_host #(.POR_LONG_CYC(400), .POR_SHORT_CYC(200), .CF2CK_CYC(50)) u_fpp_config_host (
    .i_mclk(mclk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_por_select(por_sel), .i_status_line(status_line), .o_status_out(status_out), .o_status_oe(status_oe),
    .i_complete_line(complete_line), .i_request_line(request_line), .o_request_out(request_out),
    .o_request_oe(request_oe), .o_config_clock(config_clock), .o_config_byte(config_byte),
    .o_user_clock(user_clock));
  fpp_target_model u_fpp_target_model (
    .i_mclk(mclk), .i_por_select(1'b1), .i_fail(fail), .i_request_line(request_line),
    .i_status_line(status_line), .i_config_clock(config_clock), .i_config_byte(config_byte),
    .i_user_clock(user_clock), .i_use_uclk(use_uclk), .i_pullup_sel_n(1'b0),
    .o_status_oe(tgt_status_oe), .o_complete_oe(tgt_complete_oe), .o_user_mode(user_mode),
    .o_pullups_on(pullups_on), .o_init_done_oe(init_done_oe));

  initial forever #5 mclk = ~mclk;
  always @(posedge config_clock) n_clk++;
  always @(posedge user_clock) n_uclk++;
  // hang guard, far above the expected run length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one apb transfer; answer taken at the rising edge that samples pready high, released only then
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_state(input host_state_t s);
    rd = 32'h0;
    while (rd[7:4] !== s) apb(1'b0, `REG_STAT, 32'h0);
  endtask

  task automatic t_power_on;
    repeat (150) @(negedge mclk);
    `CHK("status_oe in por", 1'b1, status_oe)
    wait_state(S_IDLE);
    `CHK("status released", 1'b1, status_line)
    `CHK("idle byte", 8'hff, config_byte)
    `CHK("request level seen", 1'b1, rd[9])
    `CHK("status drive level", 1'b0, status_out)
    `CHK("request drive level", 1'b0, request_out)
  endtask

  // second reset with the long select: enable must stay low past the short delay
  task automatic t_por_long;
    @(posedge mclk);
    por_sel <= 1'b0;
    rstn <= 1'b0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (300) @(negedge mclk);
    `CHK("long por holds", 1'b1, status_oe)
    wait_state(S_IDLE);
    `CHK("long por ends", 1'b0, status_oe)
  endtask

  task automatic t_regs;
    apb(1'b1, `REG_CTRL, 32'h6);
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK("ctrl readback", 32'h6, rd)
    apb(1'b1, `REG_DATA, 32'h1a5);
    `CHK("data outside load", 8'hff, config_byte)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    n_uclk = 0;
    repeat (20) @(posedge mclk);
    `CHK("user clock rate", 1'b1, n_uclk >= 9 && n_uclk <= 11)
    apb(1'b1, `REG_CTRL, 32'h4);
    repeat (4) @(posedge mclk);
    n_uclk = 0;
    repeat (20) @(posedge mclk);
    `CHK("user clock off", 0, n_uclk)
  endtask

  task automatic t_load(input int nb, input logic ok, input logic uc);
    int lo;
    lo = 0;
    apb(1'b1, `REG_CTRL, {29'h0, 1'b1, uc, 1'b1});
    use_uclk <= uc;
    while (request_oe !== 1'b1) @(negedge mclk);
    while (request_oe === 1'b1) begin
      @(negedge mclk);
      lo++;
    end
    `CHK("request low width", 1'b1, lo >= 200)
    wait_state(S_LOAD);
    `CHK("status high at load", 1'b1, status_line)
    `CHK("pull-ups in load", 1'b1, pullups_on)
    n_clk = 0;
    for (int i = 0; i < nb; i++) apb(1'b1, `REG_DATA, {23'h0, i == nb - 1, 8'h50 + i[7:0]});
    if (ok) begin
      wait_state(S_DONE);
      `CHK("bytes taken", 4, u_fpp_target_model.n_rx)
      `CHK("complete high", 1'b1, complete_line)
      `CHK("init done held low", 1'b0, init_done_line)
      @(negedge mclk);
      `CHK("clock parked low", 1'b0, config_clock)
      `CHK("byte parked high", 8'hff, config_byte)
      repeat (800) @(negedge mclk);
      `CHK("user mode", 1'b1, user_mode)
      `CHK("pull-ups off", 1'b0, pullups_on)
      `CHK("init done released", 1'b1, init_done_line)
    end else begin
      wait_state(S_ERROR);
      `CHK("tail pulses", nb + 64, n_clk)
      `CHK("err flag", 1'b1, rd[8])
      `CHK("status pulled", 1'b1, status_oe)
    end
  endtask

  task automatic t_abort;
    apb(1'b1, `REG_CTRL, 32'h5);
    wait_state(S_LOAD);
    apb(1'b1, `REG_DATA, 32'h50);
    fail <= 1'b1;
    wait_state(S_ERROR);
    fail <= 1'b0;
    repeat (20) @(negedge mclk);
    `CHK("host holds status", 1'b1, status_oe)
    `CHK("status line low", 1'b0, status_line)
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    t_power_on();
    t_regs();
    t_load(4, 1'b1, 1'b0);
    t_load(1, 1'b0, 1'b0);
    t_abort();
    t_load(4, 1'b1, 1'b1);
    t_por_long();
    complete_run();
  end
endmodule
`default_nettype wire
